/* File: rtl/homing_pkg.sv */
package homing_pkg;

    // register offsets (byte addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_ERROR = 8'h0c;
    localparam logic [7:0] ADDR_SIG_LATCH = 8'h10;
    localparam logic [7:0] ADDR_MEM_IDX = 8'h14;
    localparam logic [7:0] ADDR_MEM_DATA = 8'h18;

    // field positions
    localparam int CTRL_POS_EN = 0;
    localparam int CTRL_NEG_EN = 1;
    localparam int CTRL_REVERSAL = 2;
    localparam int CMD_START = 0;
    localparam int CMD_METHOD_LO = 1;
    localparam int CMD_HALT = 3;
    localparam int SIG_HOMING_BIT = 10;

    // reset values
    localparam logic [2:0] CTRL_RESET = 3'h7;

    // error codes
    localparam logic [15:0] ERR_SUMMARY = 16'ha324;
    localparam logic [15:0] ERR_LIM_DISABLED = 16'ha325;
    localparam logic [15:0] ERR_REF_NOT_FOUND = 16'ha326;
    localparam logic [15:0] ERR_LIM_AT_START = 16'ha327;
    localparam logic [15:0] ERR_LIM_NO_REVERSAL = 16'ha328;
    localparam logic [15:0] ERR_MULTI_ACTIVE = 16'ha329;
    localparam logic [15:0] ERR_POS_WRONG_DIR = 16'ha32a;
    localparam logic [15:0] ERR_NEG_WRONG_DIR = 16'ha32b;
    localparam logic [15:0] ERR_REF_SW = 16'ha32c;
    localparam logic [15:0] ERR_POS_SW = 16'ha32d;
    localparam logic [15:0] ERR_NEG_SW = 16'ha32e;

    // switch indices in the switch vector
    localparam logic [1:0] SW_REF = 2'h0;
    localparam logic [1:0] SW_POS = 2'h1;
    localparam logic [1:0] SW_NEG = 2'h2;

    // timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int MIN_ACTIVE_NS = 1000;
    localparam int SETTLE_NS = 10000;
    localparam int MIN_ACTIVE_CYC_INT = (MIN_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_CYC_INT = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] MIN_ACTIVE_CYC = 8'(MIN_ACTIVE_CYC_INT);
    localparam logic [11:0] SETTLE_CYC = 12'(SETTLE_CYC_INT);

    // error memory
    localparam int MEM_DEPTH = 8;
    localparam int MEM_AW = 3;

    typedef enum logic [1:0] {
        M_TO_POS = 2'b00,
        M_TO_NEG = 2'b01,
        M_REF_POS = 2'b10,
        M_REF_NEG = 2'b11
    } method_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SEARCH = 2'b01,
        ST_SETTLE = 2'b10
    } state_t;

endpackage : homing_pkg

/* File: rtl/switch_pulse_check.sv */
`timescale 1ns/1ps
module switch_pulse_check
    import homing_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // switch
    input wire logic sw_in,
    output logic short_out
);

    typedef struct packed {
        logic prev;
        logic [7:0] cnt;
    } chk_t;

    chk_t s;
    chk_t next_s;

    // falling edge after fewer than the minimum active cycles
    assign short_out = s.prev && !sw_in && (s.cnt < MIN_ACTIVE_CYC);

    always_comb begin
        next_s = s;
        next_s.prev = sw_in;
        if (!sw_in) begin
            next_s.cnt = 8'h00;
        end else if (s.cnt != MIN_ACTIVE_CYC) begin
            next_s.cnt = s.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule : switch_pulse_check

/* File: rtl/error_memory.sv */
`timescale 1ns/1ps
module error_memory
    import homing_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // write port
    input wire logic wr_en_in,
    input wire logic [MEM_AW-1:0] wr_addr_in,
    input wire logic [31:0] wr_data_in,
    // read port
    input wire logic [MEM_AW-1:0] rd_addr_in,
    output logic [31:0] rd_data_out
);

    typedef struct packed {
        logic [MEM_DEPTH-1:0][31:0] mem;
        logic [31:0] rdata;
    } emem_t;

    emem_t s;
    emem_t next_s;

    assign rd_data_out = s.rdata;

    always_comb begin
        next_s = s;
        next_s.rdata = s.mem[rd_addr_in];
        if (wr_en_in) begin
            next_s.mem[wr_addr_in] = wr_data_in;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule : error_memory

/* File: rtl/homing_switch_fault_monitor.sv */
`timescale 1ns/1ps
module homing_switch_fault_monitor
    import homing_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    // axis switches
    input wire logic pos_limit_in,
    input wire logic neg_limit_in,
    input wire logic ref_switch_in,
    // motion controller
    input wire logic motor_stopped_in,
    output logic homing_active_out,
    output logic move_dir_pos_out,
    output logic homing_done_out,
    output logic homing_abort_out
);

    typedef struct packed {
        state_t state;
        method_t method;
        logic active;
        logic dir_pos;
        logic reversed;
        logic [2:0] ctrl;
        logic [15:0] err_sub;
        logic err_pend;
        logic [31:0] signal_fault_latch;
        logic [MEM_AW-1:0] mem_idx;
        logic [MEM_AW-1:0] mem_wptr;
        logic [11:0] settle_cnt;
        logic [2:0] prev_sw;
        logic abort;
        logic done;
        logic [31:0] rdata;
    } mon_t;

    mon_t s;
    mon_t next_s;

    logic [2:0] sw;
    logic [2:0] rise;
    logic [2:0] short_pulse;
    logic multi;
    logic start;
    logic halt;
    logic fault;
    logic [15:0] fault_code;
    logic [1:0] in_idx;
    logic [1:0] opp_idx;
    logic [1:0] target;
    logic [31:0] mem_rdata;
    method_t new_method;
    logic new_dir;

    function automatic logic [1:0] lim_idx(input logic dir_pos);
        lim_idx = dir_pos ? SW_POS : SW_NEG;
    endfunction : lim_idx

    function automatic logic [15:0] switch_fault(input logic [1:0] idx);
        case (idx)
            SW_REF: switch_fault = ERR_REF_SW;
            SW_POS: switch_fault = ERR_POS_SW;
            default: switch_fault = ERR_NEG_SW;
        endcase
    endfunction : switch_fault

    function automatic logic more_than_one(input logic [2:0] v);
        more_than_one = (v[0] && v[1]) || (v[0] && v[2]) || (v[1] && v[2]);
    endfunction : more_than_one

    assign sw = {neg_limit_in, pos_limit_in, ref_switch_in};
    assign rise = sw & ~s.prev_sw;
    assign multi = more_than_one(sw);
    assign start = reg_wr_in && (reg_addr_in == ADDR_CMD) && reg_wdata_in[CMD_START];
    assign halt = reg_wr_in && (reg_addr_in == ADDR_CMD) && reg_wdata_in[CMD_HALT];
    assign in_idx = lim_idx(s.dir_pos);
    assign opp_idx = lim_idx(!s.dir_pos);
    assign target = s.method[1] ? SW_REF : in_idx;
    assign new_method = method_t'(reg_wdata_in[CMD_METHOD_LO +: 2]);
    assign new_dir = !new_method[0];

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_chk
            switch_pulse_check u_chk (
                .clk_sys_in(clk_sys_in),
                .rst_in(rst_in),
                .sw_in(sw[gi]),
                .short_out(short_pulse[gi])
            );
        end
    endgenerate

    error_memory u_mem (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .wr_en_in(fault),
        .wr_addr_in(s.mem_wptr),
        .wr_data_in({ERR_SUMMARY, fault_code}),
        .rd_addr_in(next_s.mem_idx),
        .rd_data_out(mem_rdata)
    );

    always_comb begin
        next_s = s;
        next_s.abort = 1'b0;
        next_s.done = 1'b0;
        next_s.prev_sw = sw;
        fault = 1'b0;
        fault_code = 16'h0000;
        if (reg_wr_in && reg_addr_in == ADDR_CTRL) begin
            next_s.ctrl = reg_wdata_in[2:0];
        end
        if (reg_wr_in && reg_addr_in == ADDR_MEM_IDX) begin
            next_s.mem_idx = reg_wdata_in[MEM_AW-1:0];
        end
        // write one to clear; a fault in the same cycle sets it again below
        if (reg_wr_in && reg_addr_in == ADDR_SIG_LATCH) begin
            next_s.signal_fault_latch = s.signal_fault_latch & ~reg_wdata_in;
        end
        case (s.state)
            ST_IDLE: begin
                if (start) begin
                    next_s.method = new_method;
                    next_s.dir_pos = new_dir;
                    next_s.reversed = 1'b0;
                    next_s.err_pend = 1'b0;
                    next_s.settle_cnt = 12'h000;
                    if ((new_method == M_TO_POS && !s.ctrl[CTRL_POS_EN]) ||
                        (new_method == M_TO_NEG && !s.ctrl[CTRL_NEG_EN])) begin
                        fault = 1'b1;
                        fault_code = ERR_LIM_DISABLED;
                    end else if (new_method[1] && !s.ctrl[CTRL_REVERSAL] &&
                                 sw[lim_idx(new_dir)]) begin
                        fault = 1'b1;
                        fault_code = ERR_LIM_AT_START;
                    end else begin
                        next_s.state = ST_SEARCH;
                    end
                end
            end
            ST_SEARCH: begin
                if (halt) begin
                    next_s.state = ST_IDLE;
                end else if (multi) begin
                    fault = 1'b1;
                    fault_code = ERR_MULTI_ACTIVE;
                end else if (|short_pulse) begin
                    fault = 1'b1;
                    fault_code = short_pulse[0] ? ERR_REF_SW :
                                 (short_pulse[1] ? ERR_POS_SW : ERR_NEG_SW);
                end else if (rise[opp_idx]) begin
                    fault = 1'b1;
                    fault_code = s.dir_pos ? ERR_NEG_WRONG_DIR : ERR_POS_WRONG_DIR;
                end else if (s.method[1] && rise[SW_REF]) begin
                    next_s.state = ST_SETTLE;
                    next_s.settle_cnt = 12'h000;
                end else if (rise[in_idx]) begin
                    if (!s.method[1]) begin
                        next_s.state = ST_SETTLE;
                        next_s.settle_cnt = 12'h000;
                    end else if (!s.ctrl[CTRL_REVERSAL]) begin
                        fault = 1'b1;
                        fault_code = ERR_LIM_NO_REVERSAL;
                    end else if (!s.reversed) begin
                        next_s.dir_pos = !s.dir_pos;
                        next_s.reversed = 1'b1;
                    end else begin
                        fault = 1'b1;
                        fault_code = ERR_REF_NOT_FOUND;
                    end
                end
            end
            ST_SETTLE: begin
                if (halt) begin
                    next_s.state = ST_IDLE;
                end else if (multi) begin
                    fault = 1'b1;
                    fault_code = ERR_MULTI_ACTIVE;
                end else if (!sw[target]) begin
                    // switch left before or after the stop
                    fault = 1'b1;
                    fault_code = switch_fault(target);
                end else if (motor_stopped_in) begin
                    if (s.settle_cnt == SETTLE_CYC - 12'h001) begin
                        next_s.state = ST_IDLE;
                        next_s.done = 1'b1;
                    end else begin
                        next_s.settle_cnt = s.settle_cnt + 12'h001;
                    end
                end else begin
                    next_s.settle_cnt = 12'h000;
                end
            end
            default: begin
                next_s.state = ST_IDLE;
            end
        endcase
        if (fault) begin
            next_s.state = ST_IDLE;
            next_s.abort = 1'b1;
            next_s.err_sub = fault_code;
            next_s.err_pend = 1'b1;
            next_s.mem_wptr = s.mem_wptr + 3'h1;
            next_s.signal_fault_latch[SIG_HOMING_BIT] = 1'b1;
        end
        next_s.active = (next_s.state != ST_IDLE);
        next_s.rdata = 32'h0000_0000;
        if (reg_rd_in) begin
            case (reg_addr_in)
                ADDR_CTRL: next_s.rdata = {29'h0, s.ctrl};
                ADDR_CMD: next_s.rdata = {29'h0, s.method, 1'b0};
                ADDR_STATUS: next_s.rdata = {28'h0, s.err_pend, s.done, s.dir_pos, s.active};
                ADDR_ERROR: next_s.rdata = {s.err_pend ? ERR_SUMMARY : 16'h0000, s.err_sub};
                ADDR_SIG_LATCH: next_s.rdata = s.signal_fault_latch;
                ADDR_MEM_IDX: next_s.rdata = {29'h0, s.mem_idx};
                ADDR_MEM_DATA: next_s.rdata = mem_rdata;
                default: next_s.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            s <= '0;
            s.ctrl <= CTRL_RESET;
            s.method <= M_TO_POS;
            s.state <= ST_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata_out = s.rdata;
    assign homing_active_out = s.active;
    assign move_dir_pos_out = s.dir_pos;
    assign homing_done_out = s.done;
    assign homing_abort_out = s.abort;

    // checks
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    logic search_clean;
    assign search_clean = (s.state == ST_SEARCH) && !halt && !multi && !(|short_pulse);

    // target switch still held while waiting for standstill
    sequence ref_held_s;
        s.state == ST_SETTLE && s.method[1] && ref_switch_in;
    endsequence

    sequence neg_held_s;
        s.state == ST_SETTLE && s.method == M_TO_NEG && neg_limit_in;
    endsequence

    lim_disabled_a: assert property (
        s.state == ST_IDLE && start && new_method == M_TO_POS && !s.ctrl[CTRL_POS_EN]
        |=> homing_abort_out && s.err_sub == ERR_LIM_DISABLED && !homing_active_out)
        else $error("disabled limit homing not aborted with a325");

    ref_not_found_a: assert property (
        search_clean && s.reversed && s.ctrl[CTRL_REVERSAL] && !rise[opp_idx] && rise[in_idx]
        |=> homing_abort_out && s.err_sub == ERR_REF_NOT_FOUND)
        else $error("reference search past both limits not aborted with a326");

    lim_at_start_a: assert property (
        s.state == ST_IDLE && start && new_method[1] && !s.ctrl[CTRL_REVERSAL] &&
        sw[lim_idx(new_dir)] && !(new_method == M_TO_POS || new_method == M_TO_NEG)
        |=> homing_abort_out && s.err_sub == ERR_LIM_AT_START)
        else $error("limit active at start not aborted with a327");

    no_reversal_a: assert property (
        search_clean && s.method[1] && !s.ctrl[CTRL_REVERSAL] && rise[in_idx]
        |=> homing_abort_out && s.err_sub == ERR_LIM_NO_REVERSAL && !homing_active_out)
        else $error("limit hit without reversal not aborted with a328");

    multi_active_a: assert property (
        s.state != ST_IDLE && !halt && multi
        |=> homing_abort_out && s.err_sub == ERR_MULTI_ACTIVE && s.state == ST_IDLE)
        else $error("several active switches not aborted with a329");

    pos_wrong_dir_a: assert property (
        search_clean && !s.dir_pos && rise[SW_POS]
        |=> homing_abort_out && s.err_sub == ERR_POS_WRONG_DIR)
        else $error("positive limit while moving negative not aborted with a32a");

    neg_wrong_dir_a: assert property (
        search_clean && s.dir_pos && rise[SW_NEG]
        |=> homing_abort_out && s.err_sub == ERR_NEG_WRONG_DIR)
        else $error("negative limit while moving positive not aborted with a32b");

    ref_overtravel_a: assert property (
        ref_held_s ##1 (s.state == ST_SETTLE && !ref_switch_in && !halt && !multi)
        |=> homing_abort_out && s.err_sub == ERR_REF_SW)
        else $error("reference switch loss not aborted with a32c");

    pos_glitch_a: assert property (
        s.state == ST_SEARCH && !halt && !multi && !short_pulse[0] && short_pulse[1]
        |=> homing_abort_out && s.err_sub == ERR_POS_SW)
        else $error("short positive limit pulse not aborted with a32d");

    neg_overtravel_a: assert property (
        neg_held_s ##1 (s.state == ST_SETTLE && !neg_limit_in && !halt && !multi)
        |=> homing_abort_out && s.err_sub == ERR_NEG_SW)
        else $error("negative limit loss not aborted with a32e");

    latch_bit_set_a: assert property (
        homing_abort_out |-> s.signal_fault_latch[SIG_HOMING_BIT])
        else $error("homing fault did not set latch bit 10");

    summary_read_a: assert property (
        s.err_pend && reg_rd_in && reg_addr_in == ADDR_ERROR && !start
        |=> reg_rdata_out[31:16] == ERR_SUMMARY && reg_rdata_out[15:0] == s.err_sub)
        else $error("summary code a324 missing after homing fault");

    latch_hold_a: assert property (
        s.signal_fault_latch[SIG_HOMING_BIT] &&
        !(reg_wr_in && reg_addr_in == ADDR_SIG_LATCH && reg_wdata_in[SIG_HOMING_BIT])
        |=> s.signal_fault_latch[SIG_HOMING_BIT])
        else $error("latch bit 10 dropped without software clear");

endmodule : homing_switch_fault_monitor

/* File: sim/axis_switch_model.sv */
`timescale 1ns/1ps
module axis_switch_model #(
    parameter int LIM_HI = 400,
    parameter int REF_LO = 300,
    parameter int REF_HI = 340,
    parameter int LAG = 250
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // motion request from the monitor
    input wire logic homing_active_in,
    input wire logic dir_pos_in,
    // bench control
    input wire logic stop_in,
    input wire logic load_in,
    input wire logic signed [15:0] load_pos_in,
    input wire logic ref_fit_in,
    input wire logic [2:0] flip_in,
    // switches and standstill
    output logic pos_limit_out,
    output logic neg_limit_out,
    output logic ref_switch_out,
    output logic motor_stopped_out
);
    logic signed [15:0] pos;
    logic dir;
    int lag;
    logic moving;
    assign moving = homing_active_in && !stop_in;
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            pos <= 16'sd100;
            dir <= 1'b1;
            lag <= 0;
            motor_stopped_out <= 1'b1;
        end else begin
            motor_stopped_out <= !moving;
            if (load_in) begin
                pos <= load_pos_in;
            end else if (moving) begin
                pos <= dir ? pos + 16'sd1 : pos - 16'sd1;
            end
            // a moving axis overtravels for LAG+1 cycles before it turns
            if (motor_stopped_out || dir == dir_pos_in || lag == LAG) begin
                dir <= dir_pos_in;
                lag <= 0;
            end else begin
                lag <= lag + 1;
            end
        end
    end
    // flip lets the bench inject glitches and wiring faults
    assign pos_limit_out = (int'(pos) >= LIM_HI) ^ flip_in[1];
    assign neg_limit_out = (int'(pos) <= 0) ^ flip_in[2];
    assign ref_switch_out = (ref_fit_in && int'(pos) >= REF_LO && int'(pos) <= REF_HI) ^ flip_in[0];
endmodule : axis_switch_model

/* File: sim/tb_homing_switch_fault_monitor.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module tb_homing_switch_fault_monitor;
    import homing_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [31:0] reg_rdata_out;
    logic pos_limit_in, neg_limit_in, ref_switch_in, motor_stopped_in;
    logic homing_active_out, move_dir_pos_out, homing_done_out, homing_abort_out;
    logic stop_in = 1'b0;
    logic load_in = 1'b0;
    logic signed [15:0] load_pos_in = 16'sh0;
    logic ref_fit_in = 1'b0;
    logic [2:0] flip_in = 3'h0;
    int mismatches = 0;
    int cmp_count = 0;
    logic [31:0] rd;
    logic [15:0] codes[$];
    int r;

    always #2.5 clk_sys_in = ~clk_sys_in;

    homing_switch_fault_monitor dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .pos_limit_in(pos_limit_in),
        .neg_limit_in(neg_limit_in), .ref_switch_in(ref_switch_in),
        .motor_stopped_in(motor_stopped_in), .homing_active_out(homing_active_out),
        .move_dir_pos_out(move_dir_pos_out), .homing_done_out(homing_done_out),
        .homing_abort_out(homing_abort_out));

    axis_switch_model axis_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .homing_active_in(homing_active_out), .dir_pos_in(move_dir_pos_out), .stop_in(stop_in),
        .load_in(load_in), .load_pos_in(load_pos_in), .ref_fit_in(ref_fit_in),
        .flip_in(flip_in), .pos_limit_out(pos_limit_in), .neg_limit_out(neg_limit_in),
        .ref_switch_out(ref_switch_in), .motor_stopped_out(motor_stopped_in));

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask : reg_read

    task automatic wait_out(input bit want_done);
        int n;
        n = 0;
        // a fault on the start write raises its pulse right after that edge
        #1;
        while (((want_done ? homing_done_out : homing_abort_out) !== 1'b1) && n < 8000) begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end
        if (n == 8000) begin
            mismatches++;
            $display("mismatch at %0t: no completion pulse", $time);
        end
    endtask : wait_out

    task automatic run_fault(input logic [2:0] ctrl, input method_t m, input int p,
        input logic rf, input logic [2:0] fm, input int fd, input int fl, input logic [15:0] exp);
        @(posedge clk_sys_in);
        load_in <= 1'b1;
        load_pos_in <= 16'(p);
        ref_fit_in <= rf;
        @(posedge clk_sys_in);
        load_in <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        reg_write(ADDR_CTRL, {29'h0, ctrl});
        reg_write(ADDR_CMD, {29'h0, m, 1'b1});
        if (fm != 3'h0) begin
            repeat (fd) @(posedge clk_sys_in);
            flip_in <= fm;
            if (fl > 0) begin
                repeat (fl) @(posedge clk_sys_in);
                flip_in <= 3'h0;
            end
        end
        wait_out(1'b0);
        `CHK(homing_active_out, 1'b0)
        @(posedge clk_sys_in);
        flip_in <= 3'h0;
        reg_read(ADDR_ERROR, rd);
        `CHK(rd, {ERR_SUMMARY, exp})
        reg_read(ADDR_SIG_LATCH, rd);
        `CHK(rd[SIG_HOMING_BIT], 1'b1)
        reg_write(ADDR_SIG_LATCH, 32'h1 << SIG_HOMING_BIT);
        reg_read(ADDR_SIG_LATCH, rd);
        `CHK(rd, 32'h0)
        codes.push_back(exp);
    endtask : run_fault

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    initial begin
        #300000;
        mismatches++;
        close_out();
    end

    initial begin
        r = $urandom(32'hd579);
        repeat (12) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        @(posedge clk_sys_in);
        #1;
        `CHK({homing_active_out, homing_done_out, homing_abort_out}, 3'b000)
        reg_read(ADDR_CTRL, rd);
        `CHK(rd, {29'h0, CTRL_RESET})
        reg_read(ADDR_SIG_LATCH, rd);
        `CHK(rd, 32'h0)
        reg_read(8'h1c, rd);
        `CHK(rd, 32'h0)
        run_fault(3'h6, M_TO_POS, 100, 0, 3'h0, 0, 0, ERR_LIM_DISABLED);
        run_fault(3'h5, M_TO_NEG, 100, 0, 3'h0, 0, 0, ERR_LIM_DISABLED);
        run_fault(3'h3, M_REF_POS, 450, 0, 3'h0, 0, 0, ERR_LIM_AT_START);
        run_fault(3'h3, M_REF_NEG, -20, 0, 3'h0, 0, 0, ERR_LIM_AT_START);
        run_fault(3'h3, M_REF_POS, 100 + int'($urandom % 40), 0, 3'h0, 0, 0,
            ERR_LIM_NO_REVERSAL);
        run_fault(3'h7, M_REF_POS, 100 + int'($urandom % 40), 0, 3'h0, 0, 0,
            ERR_REF_NOT_FOUND);
        run_fault(3'h7, M_TO_POS, 100 + int'($urandom % 40), 0, 3'h3, 5 + int'($urandom % 40), 0,
            ERR_MULTI_ACTIVE);
        run_fault(3'h7, M_TO_NEG, 250 + int'($urandom % 40), 0, 3'h2, 5 + int'($urandom % 40), 0,
            ERR_POS_WRONG_DIR);
        run_fault(3'h7, M_TO_POS, 100 + int'($urandom % 40), 0, 3'h4, 5 + int'($urandom % 40), 0,
            ERR_NEG_WRONG_DIR);
        run_fault(3'h7, M_TO_POS, 100 + int'($urandom % 40), 0, 3'h1, 5 + int'($urandom % 40),
            20 + int'($urandom % 150), ERR_REF_SW);
        run_fault(3'h7, M_REF_POS, 100 + int'($urandom % 40), 0, 3'h2, 5 + int'($urandom % 40),
            20 + int'($urandom % 150), ERR_POS_SW);
        run_fault(3'h7, M_TO_NEG, 250 + int'($urandom % 40), 0, 3'h4, 5 + int'($urandom % 40),
            20 + int'($urandom % 150), ERR_NEG_SW);
        // reference found but never stopped on: it runs off the switch
        run_fault(3'h7, M_REF_POS, 100 + int'($urandom % 40), 1, 3'h0, 0, 0, ERR_REF_SW);
        // successful reference search: stop on the switch and settle
        @(posedge clk_sys_in);
        load_in <= 1'b1;
        load_pos_in <= 16'sd100;
        ref_fit_in <= 1'b1;
        @(posedge clk_sys_in);
        load_in <= 1'b0;
        reg_write(ADDR_CMD, {29'h0, M_REF_POS, 1'b1});
        for (int n = 0; n < 1000 && ref_switch_in !== 1'b1; n++) begin
            @(posedge clk_sys_in);
            #1;
        end
        `CHK(move_dir_pos_out, 1'b1)
        @(posedge clk_sys_in);
        stop_in <= 1'b1;
        wait_out(1'b1);
        `CHK(homing_active_out, 1'b0)
        @(posedge clk_sys_in);
        stop_in <= 1'b0;
        for (int k = (codes.size() > 8 ? codes.size() - 8 : 0); k < codes.size(); k++) begin
            reg_write(ADDR_MEM_IDX, 32'(k % MEM_DEPTH));
            reg_read(ADDR_MEM_DATA, rd);
            `CHK(rd, {ERR_SUMMARY, codes[k]})
        end
        close_out();
    end
endmodule : tb_homing_switch_fault_monitor
